// >>> inc/fbwp_pkg.sv
// Package: constants and carrier types for the flash block write-protect logic
package fbwp_pkg;

   // Status register field positions
   localparam int unsigned STAT_LOCK_BIT    = 7;
   localparam int unsigned STAT_QUAD_BIT    = 6;
   localparam int unsigned STAT_LEVEL_HI    = 5;
   localparam int unsigned STAT_LEVEL_LO    = 2;
   localparam int unsigned STAT_WEL_BIT     = 1;
   localparam int unsigned STAT_WIP_BIT     = 0;

   // Reset and factory default of the status register
   localparam logic [7:0]  STAT_RESET       = 8'h00;
   // Bits that the status write may change (lock, quad, level)
   localparam logic [7:0]  STAT_WRITE_MASK  = 8'hfc;

   // Array geometry: 64 KB blocks, 24-bit byte address
   localparam int unsigned ADDR_W           = 24;
   localparam int unsigned BLOCK_SHIFT      = 16;
   localparam int unsigned BLOCK_W          = 8;

   // Density selection codes
   localparam logic [1:0]  DENS_256         = 2'h0;
   localparam logic [1:0]  DENS_128         = 2'h1;
   localparam logic [1:0]  DENS_64          = 2'h2;

   // Level at and above which the whole array is protected, per density
   localparam logic [3:0]  ALL_LEVEL_256    = 4'h9;
   localparam logic [3:0]  ALL_LEVEL_128    = 4'h8;
   localparam logic [3:0]  ALL_LEVEL_64     = 4'h7;

   // Operation kinds offered for a protection check
   typedef enum logic [1:0] {
      OP_PROGRAM  = 2'b00,
      OP_ERASE    = 2'b01,
      OP_CHIP     = 2'b10,
      OP_NONE     = 2'b11
   } fbwp_op_t;

   // Program or erase request from the command decoder
   typedef struct packed {
      logic                valid;
      fbwp_op_t            op;
      logic [ADDR_W-1:0]   addr;
      logic [ADDR_W-1:0]   last;
   } fbwp_req_t;

   // Verdict returned for one request
   typedef struct packed {
      logic                valid;
      logic                allowed;
   } fbwp_resp_t;

endpackage

// >>> hw/fbwp_core.sv
// Block write-protect, status lock and shared-pin steering for a serial NOR flash
module fbwp_core
   import fbwp_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic [1:0]          density_sel,
   input  wire logic                write_enable_command,
   input  wire logic                status_write_command,
   input  wire logic [7:0]          status_wdata,
   input  wire logic                set_bottom_command,
   input  wire fbwp_pkg::fbwp_req_t op_req,
   input  wire logic                wp_io2_in,
   input  wire logic                hold_io3_in,
   input  wire logic                io2_out,
   input  wire logic                io2_oe,
   input  wire logic                io3_out,
   input  wire logic                io3_oe,
   output logic [7:0]               status_protection_register,
   output logic                     protect_from_bottom,
   output fbwp_pkg::fbwp_resp_t     op_resp,
   output logic                     status_write_refused,
   output logic                     wp_io2_pin_out,
   output logic                     wp_io2_pin_oe,
   output logic                     hold_io3_pin_out,
   output logic                     hold_io3_pin_oe,
   output logic                     hold_n_active,
   output logic                     quad_data2_in,
   output logic                     quad_data3_in
);
   import fbwp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and status storage

   logic [1:0]  wp_sync_reg;
   logic [1:0]  hold_sync_reg;
   logic [7:0]  stat_reg;
   logic [7:0]  stat_next;
   logic        wel_reg;
   logic        wel_next;
   logic        stat_write_take;
   logic        stat_write_drop;
   logic        bottom_reg;
   logic        stat_write_ok;

   // Two-stage capture of the protect pin; first stage is read only by the second.
   // Resets to the idle-high level so no false lock or hold follows reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_sync_reg <= 2'h3;
      end else begin
         wp_sync_reg <= {wp_sync_reg[0], wp_io2_in};
      end
   end

   // Same two-stage capture for the hold pin
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_sync_reg <= 2'h3;
      end else begin
         hold_sync_reg <= {hold_sync_reg[0], hold_io3_in};
      end
   end

   // Aliases for the field layout
   logic        lock_bit;
   logic        quad_io_enable;
   logic [3:0]  level;
   logic        wp_level;
   assign lock_bit       = stat_reg[STAT_LOCK_BIT];
   assign quad_io_enable = stat_reg[STAT_QUAD_BIT];
   assign level          = stat_reg[STAT_LEVEL_HI:STAT_LEVEL_LO];
   // In quad mode the pin is data, so hardware lock cannot engage
   assign wp_level       = quad_io_enable ? 1'b1 : wp_sync_reg[1];

   // Lock freezes status only with protect pin low
   // lock with pin low
   assign stat_write_ok = !(lock_bit && !wp_level);

   // An armed status write either lands or is dropped by the lock, never both
   assign stat_write_take = status_write_command && wel_reg && stat_write_ok;
   assign stat_write_drop = status_write_command && wel_reg && !stat_write_ok;

   // Status write replaces only lock, quad and level; latch bits stay internal
   always_comb begin
      stat_next = stat_reg;
      if (stat_write_take) begin
         stat_next = (status_wdata & STAT_WRITE_MASK) | (stat_reg & ~STAT_WRITE_MASK);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= STAT_RESET;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // Write-enable latch: set by write enable, cleared by any write attempt.
   // Set wins over clear so a write enable that lands with a command still arms the next one
   // host arms the latch first
   always_comb begin
      wel_next = wel_reg;
      if (write_enable_command) begin
         wel_next = 1'b1;
      end else if (status_write_command || set_bottom_command || op_req.valid) begin
         wel_next = 1'b0;
      end
   end

   // Latch storage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_reg <= 1'b0;
      end else begin
         wel_reg <= wel_next;
      end
   end

   // Direction bit only ever goes from top to bottom
   // one-time bottom
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bottom_reg <= 1'b0;
      end else if (set_bottom_command && wel_reg) begin
         bottom_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protected range from level, density and direction

   logic [3:0]          all_level;
   logic [BLOCK_W-1:0]  max_blk;
   logic                none_prot;
   logic                all_prot;
   logic [BLOCK_W-1:0]  span_m1;
   logic [BLOCK_W-1:0]  lo_blk;
   logic [BLOCK_W-1:0]  hi_blk;

   // Density picks both the array size and the whole-array level
   always_comb begin
      unique case (density_sel)
         DENS_128: begin
            all_level = ALL_LEVEL_128;
            max_blk   = 8'h7f;
         end
         DENS_64: begin
            all_level = ALL_LEVEL_64;
            max_blk   = 8'h3f;
         end
         default: begin
            all_level = ALL_LEVEL_256;
            max_blk   = 8'hff;
         end
      endcase
   end

   // Level zero is caught first: a zero span would otherwise still cover one block
   // level zero none
   assign none_prot = (level == 4'h0);
   assign all_prot  = (level >= all_level);
   // Span of 2^(n-1) blocks less one; level is below all_level here, so n-1 <= 7
   assign span_m1   = none_prot ? 8'h00 : 8'((9'h001 << (level - 4'h1)) - 9'h001);

   always_comb begin
      if (all_prot) begin
         lo_blk = 8'h00;
         hi_blk = max_blk;
      end else if (bottom_reg) begin
         lo_blk = 8'h00;
         hi_blk = span_m1;
      end else begin
         lo_blk = max_blk - span_m1;
         hi_blk = max_blk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request verdict

   logic [BLOCK_W-1:0]  req_first;
   logic [BLOCK_W-1:0]  req_last;
   logic                overlap;
   logic                verdict;

   assign req_first = op_req.addr[BLOCK_SHIFT +: BLOCK_W];
   assign req_last  = op_req.last[BLOCK_SHIFT +: BLOCK_W];
   assign overlap   = !none_prot && (req_first <= hi_blk) && (req_last >= lo_blk);

   always_comb begin
      unique case (op_req.op)
         OP_CHIP:    verdict = wel_reg && none_prot;
         OP_PROGRAM: verdict = wel_reg && !overlap;
         OP_ERASE:   verdict = wel_reg && !overlap;
         OP_NONE:    verdict = 1'b0;
      endcase
   end

   // Verdict is registered so the decoder sees it one cycle after the request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_resp <= '0;
      end else begin
         op_resp.valid   <= op_req.valid;
         op_resp.allowed <= op_req.valid && verdict;
      end
   end

   // Pulse when a status write is dropped by the hardware lock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_write_refused <= 1'b0;
      end else begin
         status_write_refused <= stat_write_drop;
      end
   end

   // Status image for reads, with the latch in its own bit.
   // Both parts take their next value so the image never shows a latch a cycle stale
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_protection_register <= STAT_RESET;
      end else begin
         status_protection_register <= {stat_next[STAT_LOCK_BIT:STAT_LEVEL_LO], wel_next, 1'b0};
      end
   end

   // Direction image; follows the one-time bit a cycle later
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         protect_from_bottom <= 1'b0;
      end else begin
         protect_from_bottom <= bottom_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared pin steering

   // Quad mode turns pins into data; otherwise they are inputs with control meaning
   // data lines driven
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_io2_pin_out   <= 1'b0;
         wp_io2_pin_oe    <= 1'b0;
         hold_io3_pin_out <= 1'b0;
         hold_io3_pin_oe  <= 1'b0;
      end else begin
         wp_io2_pin_out   <= quad_io_enable & io2_out;
         wp_io2_pin_oe    <= quad_io_enable & io2_oe;
         hold_io3_pin_out <= quad_io_enable & io3_out;
         hold_io3_pin_oe  <= quad_io_enable & io3_oe;
      end
   end

   // Received levels: hold meaning with quad off, data with quad on; the unused one reads zero
   // control functions
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_n_active <= 1'b0;
         quad_data2_in <= 1'b0;
         quad_data3_in <= 1'b0;
      end else begin
         hold_n_active <= !quad_io_enable && !hold_sync_reg[1];
         quad_data2_in <= quad_io_enable & wp_sync_reg[1];
         quad_data3_in <= quad_io_enable & hold_sync_reg[1];
      end
   end

endmodule

// >>> verification/fbwp_properties.sv
// Port checker for the block write-protect core
module fbwp_props
   import fbwp_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire logic                 write_enable_command,
   input wire logic                 status_write_command,
   input wire logic [7:0]           status_wdata,
   input wire fbwp_pkg::fbwp_req_t  op_req,
   input wire logic                 wp_io2_in,
   input wire logic [7:0]           status_protection_register,
   input wire logic                 protect_from_bottom,
   input wire fbwp_pkg::fbwp_resp_t op_resp,
   input wire logic                 status_write_refused,
   input wire logic                 wp_io2_pin_oe,
   input wire logic                 hold_io3_pin_oe,
   input wire logic                 hold_n_active,
   input wire logic                 quad_data2_in
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] sr;
   assign sr = status_protection_register;
   ////////////////////////////////////////////////////////////
   // Pin must sit low through the synchroniser before a lock bites
   sequence s_pin_low; !wp_io2_in [*4]; endsequence
   sequence s_locked_wr; status_write_command && sr[7] && sr[1] && !sr[6] && !write_enable_command; endsequence
   property p_resp; op_req.valid |=> op_resp.valid; endproperty
   property p_no_resp; !op_req.valid |=> !op_resp.valid; endproperty
   property p_chip; op_req.valid && op_req.op == OP_CHIP && sr[5:2] != 4'h0 |=> !op_resp.allowed; endproperty
   property p_latch; op_req.valid && !sr[1] && !write_enable_command |=> !op_resp.allowed; endproperty
   property p_locked; s_pin_low ##0 s_locked_wr |=> $stable(sr[7:2]) && status_write_refused; endproperty
   property p_open;
      status_write_command && sr[1] && !sr[7] && !write_enable_command |=> sr[7:2] == $past(status_wdata[7:2]);
   endproperty
   property p_refused; status_write_refused |-> $past(status_write_command) && $past(sr[7]); endproperty
   property p_bottom; protect_from_bottom |=> protect_from_bottom; endproperty
   property p_quad_off; !sr[6] |=> !wp_io2_pin_oe && !hold_io3_pin_oe && !quad_data2_in; endproperty
   property p_quad_on; sr[6] |=> !hold_n_active; endproperty
   a_resp: assert property (p_resp) else $error("no verdict after request");
   a_no_resp: assert property (p_no_resp) else $error("verdict without request");
   a_chip: assert property (p_chip) else $error("chip erase allowed with level set");
   a_latch: assert property (p_latch) else $error("operation allowed without latch");
   a_locked: assert property (p_locked) else $error("locked status changed");
   a_open: assert property (p_open) else $error("unlocked status write lost");
   a_refused: assert property (p_refused) else $error("spurious refusal");
   a_bottom: assert property (p_bottom) else $error("direction returned to top");
   a_quad_off: assert property (p_quad_off) else $error("data lines active with quad off");
   a_quad_on: assert property (p_quad_on) else $error("hold active in quad mode");
endmodule
bind fbwp_core fbwp_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .write_enable_command(write_enable_command),
   .status_write_command(status_write_command), .status_wdata(status_wdata), .op_req(op_req),
   .wp_io2_in(wp_io2_in), .status_protection_register(status_protection_register),
   .protect_from_bottom(protect_from_bottom), .op_resp(op_resp), .status_write_refused(status_write_refused),
   .wp_io2_pin_oe(wp_io2_pin_oe), .hold_io3_pin_oe(hold_io3_pin_oe), .hold_n_active(hold_n_active),
   .quad_data2_in(quad_data2_in));

// >>> verification/fbwp_host.sv
// Host controller model issuing instructions to the core
module fbwp_host
   import fbwp_pkg::*;
(
   input  wire logic ref_clk,
   output logic      we,
   output logic      sw,
   output logic [7:0] wd,
   output logic      sb,
   output fbwp_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      we = 1'b0;
      sw = 1'b0;
      wd = 8'h00;
      sb = 1'b0;
      req = '0;
   end
   // Kind 0 status write, 1 set bottom, 2 operation, 3 operation lacking write enable
   task automatic issue(input int k, input logic [7:0] d, input fbwp_op_t op, input logic [23:0] a, l);
      // write enable ahead of each write except kind 3
      if (k != 3) begin
         @(posedge ref_clk);
         #1 we = 1;
      end
      @(posedge ref_clk);
      #1 we = 0;
      case (k)
         0: begin
            sw = 1;
            wd = d;
         end
         1: sb = 1;
         default: req = '{1'b1, op, a, l};
      endcase
      @(posedge ref_clk);
      // Released lines show inverted data so stale values are never trusted
      #1 sw = 0;
      sb = 0;
      wd = ~d;
      req = '{1'b0, OP_NONE, ~a, ~l};
   endtask
endmodule

// >>> verification/fbwp_tb.sv
// Self-checking testbench for the block write-protect core
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fbwp_pkg::*;
   logic       ref_clk = 1'b0, rst_n = 1'b0, wp = 1'b1, hold = 1'b1, io = 1'b0;
   logic [1:0] dens = DENS_256;
   logic       we, sw, sb, bot, refu, o2, e2, o3, e3, hn, d2, d3;
   logic [7:0] wd, spr;
   fbwp_req_t  req;
   fbwp_resp_t rsp;
   int         miscompares = 0, cmp_count = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   fbwp_host host (.ref_clk(ref_clk), .we(we), .sw(sw), .wd(wd), .sb(sb), .req(req));
   fbwp_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .density_sel(dens), .write_enable_command(we),
      .status_write_command(sw), .status_wdata(wd), .set_bottom_command(sb), .op_req(req),
      .wp_io2_in(wp), .hold_io3_in(hold), .io2_out(io), .io2_oe(io), .io3_out(io), .io3_oe(io),
      .status_protection_register(spr), .protect_from_bottom(bot), .op_resp(rsp),
      .status_write_refused(refu), .wp_io2_pin_out(o2), .wp_io2_pin_oe(e2), .hold_io3_pin_out(o3),
      .hold_io3_pin_oe(e3), .hold_n_active(hn), .quad_data2_in(d2), .quad_data3_in(d3));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard: whole run needs well under 3000 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         miscompares++;
         results();
      end
   end
   // Protected when inside the lowest or highest min(2^(lv-1), n) blocks
   function automatic logic prot(input int n, input logic b, input int lv, input int blk);
      int c;
      c = (lv == 0) ? 0 : (((1 << (lv - 1)) > n) ? n : (1 << (lv - 1)));
      return b ? (blk < c) : (blk >= n - c);
   endfunction
   task automatic wr(input logic [7:0] d);
      host.issue(0, d, OP_NONE, 24'h0, 24'h0);
   endtask
   task automatic op(input int k, input fbwp_op_t o, input int b0, b1, input logic ok);
      host.issue(k, 8'h00, o, 24'(b0 << 16), 24'(b1 << 16) | 24'h00ffff);
      chk("verdict", {7'h01, ok}, {6'h00, rsp});
   endtask
   // Every level on every density, probing both ends and both sides of the edge
   task automatic sweep(input logic b);
      int n, p, k;
      int bl[6];
      for (int d = 0; d < 3; d++) begin
         dens = 2'(d);
         n = 256 >> d;
         for (int lv = 0; lv < 16; lv++) begin
            wr({2'b00, 4'(lv), 2'b00});
            chk("status", {2'b00, 4'(lv), 2'b00}, spr);
            p = (lv == 0) ? 1 : 1 << (lv - 1);
            bl = '{0, n - 1, p - 1, p, n - p - 1, n - p};
            foreach (bl[i]) begin
               k = bl[i] < 0 ? 0 : (bl[i] > n - 1 ? n - 1 : bl[i]);
               op(2, (i % 2) ? OP_ERASE : OP_PROGRAM, k, k, !prot(n, b, lv, k));
            end
         end
      end
      dens = DENS_256;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      sweep(1'b0);
      wr(8'h00);
      op(2, OP_CHIP, 0, 0, 1'b1);
      op(3, OP_PROGRAM, 0, 0, 1'b0);
      wr(8'h04);
      op(2, OP_CHIP, 0, 0, 1'b0);
      op(2, OP_ERASE, 250, 255, 1'b0);
      op(2, OP_ERASE, 0, 254, 1'b1);
      wr(8'h80);
      wr(8'h84);
      chk("status", 8'h84, spr);
      chk("refused", 8'h00, {7'h00, refu});
      wp = 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(8'h80);
      chk("status", 8'h84, spr);
      chk("refused", 8'h01, {7'h00, refu});
      wp = 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(8'h00);
      chk("status", 8'h00, spr);
      wp = 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(8'h08);
      chk("status", 8'h08, spr);
      io = 1'b1;
      wp = 1'b1;
      // shared pins are driven by the bench, never tied to a rail
      wr(8'h40);
      repeat (4) @(posedge ref_clk);
      #1 chk("pins", 8'h7e, {1'b0, o2, e2, o3, e3, d2, d3, hn});
      hold = 1'b0;
      wr(8'h00);
      repeat (4) @(posedge ref_clk);
      #1 chk("pins", 8'h01, {1'b0, o2, e2, o3, e3, d2, d3, hn});
      host.issue(1, 8'h00, OP_NONE, 24'h0, 24'h0);
      sweep(1'b1);
      chk("bottom", 8'h01, {7'h00, bot});
      results();
   end
endmodule
